// >>> logic/gcfg_top.v
// global option register bank with index/data configuration port
`timescale 1ns/1ps
`include "gcfg_map.vh"
module gcfg_top #(
  parameter PRN_W = 8,
  parameter SER_W = 4,
  parameter PIN_W = 13
) (
  input  wire             REF_CLK_I,
  input  wire             RST_I,
  input  wire [15:0]      IO_ADDR_I,
  input  wire [7:0]       IO_WDATA_I,
  input  wire             IO_WR_I,
  input  wire             IO_RD_I,
  output reg  [7:0]       IO_RDATA_O,
  output reg              IO_ACK_O,
  input  wire             STRAP_PORT_SEL_I,
  input  wire             STRAP_FLOPPY_DIS_I,
  output wire             READY_O,
  output wire             CONFIG_MODE_O,
  output wire             CONFIG_LOCKED_O,
  output wire             PORT_SELECT_O,
  output wire             FLOPPY_ENABLE_O,
  output wire             FLOPPY_HIZ_O,
  output wire             PRINTER_HIZ_O,
  output wire             SERIAL_A_HIZ_O,
  output wire             SERIAL_B_HIZ_O,
  input  wire [PRN_W-1:0] PRINTER_OE_I,
  input  wire [SER_W-1:0] SERIAL_A_OE_I,
  input  wire [SER_W-1:0] SERIAL_B_OE_I,
  output reg  [PRN_W-1:0] PRINTER_OE_O,
  output reg  [SER_W-1:0] SERIAL_A_OE_O,
  output reg  [SER_W-1:0] SERIAL_B_OE_O,
  input  wire             FLOPPY_IRQ_I,
  input  wire             FLOPPY_DOR_IRQ_GATE_I,
  input  wire             PRINTER_IRQ_I,
  input  wire             PRINTER_CTRL_IRQ_GATE_I,
  input  wire [5:0]       SERIAL_IRQ_I,
  output reg              FLOPPY_IRQ_O,
  output reg              PRINTER_IRQ_O,
  output reg  [5:0]       SERIAL_IRQ_O,
  output wire             FLOPPY_LEGACY_IRQ_OFF_O,
  output wire             PRINTER_LEGACY_IRQ_OFF_O,
  output wire [5:0]       SERIAL_LEGACY_IRQ_OFF_O,
  output wire [2:0]       PARALLEL_MODE_O,
  output wire             PARALLEL_PORT_EN_O,
  input  wire [PIN_W-1:0] FLOPPY_PIN_OUT_I,
  input  wire [PIN_W-1:0] FLOPPY_PIN_OE_I,
  input  wire [PIN_W-1:0] ALT_PIN_OUT_I,
  input  wire [PIN_W-1:0] ALT_PIN_OE_I,
  input  wire [PIN_W-1:0] SHARED_PIN_IN_I,
  output wire [PIN_W-1:0] SHARED_PIN_OUT_O,
  output wire [PIN_W-1:0] SHARED_PIN_OE_O,
  output wire [PIN_W-1:0] FLOPPY_PIN_IN_O,
  output wire [PIN_W-1:0] ALT_PIN_IN_O
);

  // configuration port sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_KEY1 = 2'b01;
  localparam [1:0] ST_CFG  = 2'b10;

  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg  [7:0]       index;
  reg  [7:0]       tristate;
  reg  [7:0]       opts;
  reg  [7:0]       serirq;
  reg  [7:0]       global_opt;
  reg  [1:0]       strap_cnt;
  reg              strap_done;
  reg  [7:0]       rd_value;
  wire [1:0]       strap_sync;
  wire [PIN_W-1:0] pin_in_sync;
  wire             port_sel;
  wire             hit_index;
  wire             hit_data;
  wire             hit_any;
  wire             in_cfg;
  wire             reg_open;
  wire             wr_data;
  wire             rd_data;
  wire             wr_index;

  // address match for one port of the active pair
  function port_hit;
    input [15:0] addr;
    input        sel;
    input        data_port;
    reg   [15:0] want;
    begin
      if (sel) begin
        want = data_port ? `GCFG_PORT_HI_DATA : `GCFG_PORT_HI_INDEX;
      end else begin
        want = data_port ? `GCFG_PORT_LO_DATA : `GCFG_PORT_LO_INDEX;
      end
      port_hit = (addr == want);
    end
  endfunction

  // straps are pins, so they cross two flops before capture
  gcfg_sync #(
    .W (2)
  ) u_strap_sync (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .async_i ({STRAP_PORT_SEL_I, STRAP_FLOPPY_DIS_I}),
    .sync_o  (strap_sync)
  );

  // shared pin inputs also come from outside
  gcfg_sync #(
    .W (PIN_W)
  ) u_pin_sync (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .async_i (SHARED_PIN_IN_I),
    .sync_o  (pin_in_sync)
  );

  // strap capture: third edge after release, once synchroniser is full
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == `GCFG_STRAP_WAIT) begin
        strap_done <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // index/data pair chosen by port select
  assign port_sel  = opts[`GCFG_BIT_PORT_SEL];
  assign hit_index = strap_done & port_hit(IO_ADDR_I, port_sel, 1'b0);
  assign hit_data  = strap_done & port_hit(IO_ADDR_I, port_sel, 1'b1);
  assign hit_any   = (hit_index | hit_data) & (IO_WR_I | IO_RD_I);
  assign in_cfg    = (state == ST_CFG);

  // lock keeps the option register itself open so it can be undone
  assign reg_open  = in_cfg & (~opts[`GCFG_BIT_LOCK] | (index == `GCFG_IDX_OPTS));
  assign wr_index  = hit_index & IO_WR_I;
  assign wr_data   = hit_data & IO_WR_I & reg_open;
  assign rd_data   = hit_data & IO_RD_I & ~IO_WR_I & reg_open;

  // entry key sequence, broken by any other access to the pair
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (wr_index && IO_WDATA_I == `GCFG_KEY_ENTER) begin
          next_state = ST_KEY1;
        end
      end
      ST_KEY1: begin
        if (wr_index && IO_WDATA_I == `GCFG_KEY_ENTER) begin
          next_state = ST_CFG;
        end else if (hit_any) begin
          next_state = ST_IDLE;
        end
      end
      ST_CFG: begin
        if (wr_index && IO_WDATA_I == `GCFG_KEY_EXIT) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer state and index latch
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      index <= 8'h00;
    end else begin
      state <= next_state;
      if (in_cfg && wr_index && IO_WDATA_I != `GCFG_KEY_EXIT) begin
        index <= IO_WDATA_I;
      end
    end
  end

  // register writes; reserved bits are masked so they always read zero
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tristate   <= `GCFG_RST_TRISTATE;
      opts       <= `GCFG_RST_OPTS;
      serirq     <= `GCFG_RST_SERIRQ;
      global_opt <= `GCFG_RST_GLOBAL;
    end else if (!strap_done) begin
      if (strap_cnt == `GCFG_STRAP_WAIT) begin
        opts[`GCFG_BIT_PORT_SEL] <= strap_sync[1];
        global_opt[`GCFG_BIT_FDD_DIS] <= strap_sync[0];
      end
    end else if (wr_data) begin
      case (index)
        `GCFG_IDX_TRISTATE: begin
          tristate <= IO_WDATA_I & `GCFG_MSK_TRISTATE;
        end
        `GCFG_IDX_OPTS: begin
          opts <= IO_WDATA_I & (`GCFG_MSK_OPTS | (8'h01 << `GCFG_BIT_PORT_SEL));
        end
        `GCFG_IDX_SERIRQ: begin
          serirq <= IO_WDATA_I & `GCFG_MSK_SERIRQ;
        end
        `GCFG_IDX_GLOBAL: begin
          global_opt <= IO_WDATA_I & `GCFG_MSK_GLOBAL;
        end
        default: begin
          tristate <= tristate;
        end
      endcase
    end
  end

  // read mux; the reserved slot and unknown indices read zero
  always @* begin
    case (index)
      `GCFG_IDX_GLOBAL:   rd_value = global_opt;
      `GCFG_IDX_TRISTATE: rd_value = tristate;
      `GCFG_IDX_OPTS:     rd_value = opts;
      `GCFG_IDX_RSVD:     rd_value = 8'h00;
      `GCFG_IDX_SERIRQ:   rd_value = serirq;
      default:            rd_value = 8'h00;
    endcase
  end

  // one-cycle acknowledge for every access to the active pair once ready
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      IO_ACK_O   <= 1'b0;
      IO_RDATA_O <= `GCFG_READ_IDLE;
    end else begin
      IO_ACK_O <= hit_any;
      if (hit_index && IO_RD_I && !IO_WR_I) begin
        IO_RDATA_O <= in_cfg ? index : `GCFG_READ_IDLE;
      end else if (rd_data) begin
        IO_RDATA_O <= rd_value;
      end else if (hit_data && IO_RD_I && !IO_WR_I) begin
        IO_RDATA_O <= `GCFG_READ_IDLE;
      end
    end
  end

  // status levels straight from the registers
  assign READY_O         = strap_done;
  assign CONFIG_MODE_O   = in_cfg;
  assign CONFIG_LOCKED_O = opts[`GCFG_BIT_LOCK];
  assign PORT_SELECT_O   = port_sel;
  assign FLOPPY_ENABLE_O = ~global_opt[`GCFG_BIT_FDD_DIS];
  assign FLOPPY_HIZ_O    = tristate[`GCFG_BIT_FDD_HIZ];
  assign PRINTER_HIZ_O   = tristate[`GCFG_BIT_PRN_HIZ];
  assign SERIAL_A_HIZ_O  = tristate[`GCFG_BIT_SER_A_HIZ];
  assign SERIAL_B_HIZ_O  = tristate[`GCFG_BIT_SER_B_HIZ];

  // output enable gating; a floated function keeps running internally
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRINTER_OE_O  <= {PRN_W{1'b0}};
      SERIAL_A_OE_O <= {SER_W{1'b0}};
      SERIAL_B_OE_O <= {SER_W{1'b0}};
    end else begin
      PRINTER_OE_O  <= PRINTER_OE_I & {PRN_W{~PRINTER_HIZ_O}};
      SERIAL_A_OE_O <= SERIAL_A_OE_I & {SER_W{~SERIAL_A_HIZ_O}};
      SERIAL_B_OE_O <= SERIAL_B_OE_I & {SER_W{~SERIAL_B_HIZ_O}};
    end
  end

  // legacy selection flags, active high means legacy selection is off
  assign FLOPPY_LEGACY_IRQ_OFF_O  = opts[`GCFG_BIT_FDD_LEG];
  assign PRINTER_LEGACY_IRQ_OFF_O = opts[`GCFG_BIT_PRN_LEG];
  assign SERIAL_LEGACY_IRQ_OFF_O[0] = opts[`GCFG_BIT_SER_A_LEG];
  assign SERIAL_LEGACY_IRQ_OFF_O[1] = opts[`GCFG_BIT_SER_B_LEG];
  assign SERIAL_LEGACY_IRQ_OFF_O[2] = serirq[4];
  assign SERIAL_LEGACY_IRQ_OFF_O[3] = serirq[5];
  assign SERIAL_LEGACY_IRQ_OFF_O[4] = serirq[6];
  assign SERIAL_LEGACY_IRQ_OFF_O[5] = serirq[7];

  // interrupt routing, registered to keep outputs glitch free
  always @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      FLOPPY_IRQ_O  <= 1'b0;
      PRINTER_IRQ_O <= 1'b0;
      SERIAL_IRQ_O  <= 6'h00;
    end else begin
      FLOPPY_IRQ_O  <= FLOPPY_IRQ_I & (FLOPPY_LEGACY_IRQ_OFF_O | FLOPPY_DOR_IRQ_GATE_I);
      PRINTER_IRQ_O <= PRINTER_IRQ_I & (PRINTER_LEGACY_IRQ_OFF_O | PRINTER_CTRL_IRQ_GATE_I);
      // handshake bit never gates serial requests in either setting
      SERIAL_IRQ_O  <= SERIAL_IRQ_I;
    end
  end

  // parallel mode only when top mode bit clear
  assign PARALLEL_MODE_O    = serirq[2:0];
  assign PARALLEL_PORT_EN_O = ~serirq[`GCFG_BIT_MODE_TOP];

  // shared pins follow the floppy enable bit
  gcfg_pin_mux #(
    .W (PIN_W)
  ) u_pin_mux (
    .clk_i        (REF_CLK_I),
    .rst_i        (RST_I),
    .floppy_en_i  (FLOPPY_ENABLE_O),
    .floppy_hiz_i (FLOPPY_HIZ_O),
    .fdd_out_i    (FLOPPY_PIN_OUT_I),
    .fdd_oe_i     (FLOPPY_PIN_OE_I),
    .alt_out_i    (ALT_PIN_OUT_I),
    .alt_oe_i     (ALT_PIN_OE_I),
    .pin_in_i     (pin_in_sync),
    .pin_out_o    (SHARED_PIN_OUT_O),
    .pin_oe_o     (SHARED_PIN_OE_O),
    .fdd_in_o     (FLOPPY_PIN_IN_O),
    .alt_in_o     (ALT_PIN_IN_O)
  );

endmodule

// >>> logic/gcfg_map.vh
// register map, field positions, reset values and keys for the global option bank
// What this block does
// - tri-state bit 5 set floats the second serial port outputs.
// - tri-state bit 4 set floats the first serial port outputs.
// - tri-state bit 3 set floats the printer port outputs.
// - tri-state bit 0 set floats the floppy controller outputs.
// - tri-state register resets to zero; bits 7-6 and 2-1 reserved.
// - entry key is 87h written twice to 2E, or 4E when port select set.
// - port select bit 6 of option register loads from strap; rest resets zero.
// - lock bit 5 set blocks configuration register reads and writes, except to the option register itself.
// - floppy legacy on gates floppy interrupt with digital output bit 3.
// - printer legacy on gates printer interrupt with control bit 4.
// - bit 1 turns first serial legacy interrupt selection off; handshake bit ignored.
// - bit 0 turns second serial legacy interrupt selection off; handshake bit ignored.
// - option 3 bit 7 turns sixth serial legacy selection off.
// - option 3 bit 6 turns fifth serial legacy selection off.
// - option 3 bit 5 turns fourth serial legacy selection off.
// - option 3 bit 4 turns third serial legacy selection off.
// - mode field bits 2-0 select parallel port when top bit clear.
// - serial option register resets to zero; bit 3 reserved.
// - floppy enable bit loads from strap; 0 enables, 1 disables.
// - registers reached by index/data pair 2E/2F or 4E/4F.
`ifndef GCFG_MAP_VH
`define GCFG_MAP_VH
`define GCFG_PORT_LO_INDEX 16'h002E
`define GCFG_PORT_LO_DATA  16'h002F
`define GCFG_PORT_HI_INDEX 16'h004E
`define GCFG_PORT_HI_DATA  16'h004F
`define GCFG_KEY_ENTER     8'h87
`define GCFG_KEY_EXIT      8'hAA
`define GCFG_IDX_GLOBAL    8'h24
`define GCFG_IDX_TRISTATE  8'h25
`define GCFG_IDX_OPTS      8'h26
`define GCFG_IDX_RSVD      8'h27
`define GCFG_IDX_SERIRQ    8'h28
`define GCFG_RST_TRISTATE  8'h00
`define GCFG_RST_OPTS      8'h00
`define GCFG_RST_SERIRQ    8'h00
`define GCFG_RST_GLOBAL    8'h00
`define GCFG_MSK_TRISTATE  8'h39
`define GCFG_MSK_OPTS      8'h6F
`define GCFG_MSK_SERIRQ    8'hF7
`define GCFG_MSK_GLOBAL    8'h02
`define GCFG_BIT_SER_B_HIZ 5
`define GCFG_BIT_SER_A_HIZ 4
`define GCFG_BIT_PRN_HIZ   3
`define GCFG_BIT_FDD_HIZ   0
`define GCFG_BIT_PORT_SEL  6
`define GCFG_BIT_LOCK      5
`define GCFG_BIT_FDD_LEG   3
`define GCFG_BIT_PRN_LEG   2
`define GCFG_BIT_SER_A_LEG 1
`define GCFG_BIT_SER_B_LEG 0
`define GCFG_BIT_FDD_DIS   1
`define GCFG_BIT_MODE_TOP  2
`define GCFG_READ_IDLE     8'hFF
`define GCFG_STRAP_WAIT    2'h2
`endif

// >>> logic/gcfg_sync.v
// two flip-flop synchroniser for pins and straps
`timescale 1ns/1ps
module gcfg_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta   <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// >>> logic/gcfg_pin_mux.v
// shared pin routing between floppy controller and sixth serial/gpio group
`timescale 1ns/1ps
module gcfg_pin_mux #(
  parameter W = 13
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         floppy_en_i,
  input  wire         floppy_hiz_i,
  input  wire [W-1:0] fdd_out_i,
  input  wire [W-1:0] fdd_oe_i,
  input  wire [W-1:0] alt_out_i,
  input  wire [W-1:0] alt_oe_i,
  input  wire [W-1:0] pin_in_i,
  output reg  [W-1:0] pin_out_o,
  output reg  [W-1:0] pin_oe_o,
  output reg  [W-1:0] fdd_in_o,
  output reg  [W-1:0] alt_in_o
);
  // unselected side sees all ones, the idle level of its active-low inputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_o <= {W{1'b0}};
      pin_oe_o  <= {W{1'b0}};
      fdd_in_o  <= {W{1'b1}};
      alt_in_o  <= {W{1'b1}};
    end else if (floppy_en_i) begin
      pin_out_o <= fdd_out_i;
      pin_oe_o  <= fdd_oe_i & {W{~floppy_hiz_i}};
      fdd_in_o  <= pin_in_i;
      alt_in_o  <= {W{1'b1}};
    end else begin
      pin_out_o <= alt_out_i;
      pin_oe_o  <= alt_oe_i;
      fdd_in_o  <= {W{1'b1}};
      alt_in_o  <= pin_in_i;
    end
  end
endmodule

// >>> bench/gcfg_props.sv
// assertion checker for the global option bank ports
`timescale 1ns/1ps
module gcfg_props #(
  parameter PRN_W = 8,
  parameter PIN_W = 13
) (
  input wire             REF_CLK_I,
  input wire             RST_I,
  input wire [15:0]      IO_ADDR_I,
  input wire             IO_WR_I,
  input wire             IO_RD_I,
  input wire             IO_ACK_O,
  input wire             READY_O,
  input wire             PORT_SELECT_O,
  input wire             STRAP_PORT_SEL_I,
  input wire             CONFIG_LOCKED_O,
  input wire             PRINTER_HIZ_O,
  input wire [PRN_W-1:0] PRINTER_OE_I,
  input wire [PRN_W-1:0] PRINTER_OE_O,
  input wire             FLOPPY_ENABLE_O,
  input wire             FLOPPY_HIZ_O,
  input wire [PIN_W-1:0] FLOPPY_PIN_OE_I,
  input wire [PIN_W-1:0] SHARED_PIN_OE_O,
  input wire             FLOPPY_IRQ_I,
  input wire             FLOPPY_DOR_IRQ_GATE_I,
  input wire             FLOPPY_LEGACY_IRQ_OFF_O,
  input wire             FLOPPY_IRQ_O,
  input wire             PRINTER_IRQ_I,
  input wire             PRINTER_CTRL_IRQ_GATE_I,
  input wire             PRINTER_LEGACY_IRQ_OFF_O,
  input wire             PRINTER_IRQ_O,
  input wire [5:0]       SERIAL_IRQ_I,
  input wire [5:0]       SERIAL_IRQ_O,
  input wire [2:0]       PARALLEL_MODE_O,
  input wire             PARALLEL_PORT_EN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  // registered paths are checked only once the cycle before was out of reset
  prn_hiz_a: assert property (!$past(RST_I) |-> PRINTER_OE_O == ($past(PRINTER_OE_I) & {PRN_W{!$past(PRINTER_HIZ_O)}}))
    else $error("printer enables not gated by float bit");
  fdd_pin_hiz_a: assert property (!$past(RST_I) && $past(FLOPPY_ENABLE_O) |->
    SHARED_PIN_OE_O == ($past(FLOPPY_PIN_OE_I) & {PIN_W{!$past(FLOPPY_HIZ_O)}}))
    else $error("floppy pin enables not gated by float bit");
  fdd_irq_a: assert property (!$past(RST_I) |->
    FLOPPY_IRQ_O == $past(FLOPPY_IRQ_I & (FLOPPY_LEGACY_IRQ_OFF_O | FLOPPY_DOR_IRQ_GATE_I)))
    else $error("floppy interrupt gating wrong");
  prn_irq_a: assert property (!$past(RST_I) |->
    PRINTER_IRQ_O == $past(PRINTER_IRQ_I & (PRINTER_LEGACY_IRQ_OFF_O | PRINTER_CTRL_IRQ_GATE_I)))
    else $error("printer interrupt gating wrong");
  ser_irq_a: assert property (!$past(RST_I) |-> SERIAL_IRQ_O == $past(SERIAL_IRQ_I))
    else $error("serial interrupts altered");
  par_mode_a: assert property (PARALLEL_PORT_EN_O == !PARALLEL_MODE_O[2])
    else $error("parallel enable disagrees with mode field");
  key_port_a: assert property (READY_O && IO_WR_I && IO_ADDR_I == (PORT_SELECT_O ? 16'h004E : 16'h002E) |=> IO_ACK_O)
    else $error("active index port write not acknowledged");
  wrong_port_a: assert property (READY_O && (IO_WR_I || IO_RD_I) &&
    IO_ADDR_I == (PORT_SELECT_O ? 16'h002E : 16'h004E) |=> !IO_ACK_O)
    else $error("inactive port answered");
  strap_sel_a: assert property ($rose(READY_O) |-> PORT_SELECT_O == STRAP_PORT_SEL_I)
    else $error("port select not loaded from strap");
  early_ack_a: assert property (!READY_O |=> !IO_ACK_O)
    else $error("access answered before ready");
  cover property ($rose(CONFIG_LOCKED_O));
  cover property (FLOPPY_IRQ_O && !FLOPPY_DOR_IRQ_GATE_I);
  cover property ($fell(FLOPPY_ENABLE_O));
  cover property ($rose(PORT_SELECT_O));
endmodule
bind gcfg_top gcfg_props #(.PRN_W(PRN_W), .PIN_W(PIN_W)) u_props (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .IO_ADDR_I(IO_ADDR_I), .IO_WR_I(IO_WR_I), .IO_RD_I(IO_RD_I),
  .IO_ACK_O(IO_ACK_O), .READY_O(READY_O), .PORT_SELECT_O(PORT_SELECT_O), .STRAP_PORT_SEL_I(STRAP_PORT_SEL_I),
  .CONFIG_LOCKED_O(CONFIG_LOCKED_O), .PRINTER_HIZ_O(PRINTER_HIZ_O), .PRINTER_OE_I(PRINTER_OE_I),
  .PRINTER_OE_O(PRINTER_OE_O), .FLOPPY_ENABLE_O(FLOPPY_ENABLE_O), .FLOPPY_HIZ_O(FLOPPY_HIZ_O),
  .FLOPPY_PIN_OE_I(FLOPPY_PIN_OE_I), .SHARED_PIN_OE_O(SHARED_PIN_OE_O), .FLOPPY_IRQ_I(FLOPPY_IRQ_I),
  .FLOPPY_DOR_IRQ_GATE_I(FLOPPY_DOR_IRQ_GATE_I), .FLOPPY_LEGACY_IRQ_OFF_O(FLOPPY_LEGACY_IRQ_OFF_O),
  .FLOPPY_IRQ_O(FLOPPY_IRQ_O), .PRINTER_IRQ_I(PRINTER_IRQ_I), .PRINTER_CTRL_IRQ_GATE_I(PRINTER_CTRL_IRQ_GATE_I),
  .PRINTER_LEGACY_IRQ_OFF_O(PRINTER_LEGACY_IRQ_OFF_O), .PRINTER_IRQ_O(PRINTER_IRQ_O),
  .SERIAL_IRQ_I(SERIAL_IRQ_I), .SERIAL_IRQ_O(SERIAL_IRQ_O), .PARALLEL_MODE_O(PARALLEL_MODE_O),
  .PARALLEL_PORT_EN_O(PARALLEL_PORT_EN_O)
);

// >>> bench/tb_top.sv
// self-checking testbench for the global option bank
`timescale 1ns/1ps
module tb_top;
  localparam [15:0] LO = 16'h002E;
  localparam [15:0] HI = 16'h004E;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [15:0] addr = 16'h0000;
  reg  [7:0]  wdat = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         s_ps = 1'b0;
  reg         s_fd = 1'b0;
  reg  [7:0]  prn_oe = 8'h00;
  reg  [3:0]  sa_oe = 4'h0;
  reg  [3:0]  sb_oe = 4'h0;
  reg         f_irq = 1'b0;
  reg         f_gate = 1'b0;
  reg         p_irq = 1'b0;
  reg         p_gate = 1'b0;
  reg  [5:0]  s_irq = 6'h00;
  reg  [12:0] f_out = 13'h0000;
  reg  [12:0] f_oe = 13'h0000;
  reg  [12:0] a_out = 13'h0000;
  reg  [12:0] a_oe = 13'h0000;
  reg  [12:0] pin_in = 13'h0F0F;
  wire [7:0]  rdata;
  wire        ack, ready, cmode, locked, psel, fen, pen, f_irq_o, p_irq_o;
  wire [7:0]  prn_oe_o;
  wire [3:0]  sa_oe_o, sb_oe_o;
  wire [5:0]  s_irq_o, s_leg;
  wire [2:0]  pmode;
  wire [12:0] sh_out, sh_oe;
  wire [12:0] f_in_o, a_in_o;
  wire [3:0]  hiz;
  wire        f_leg, p_leg;
  integer     num_errors = 0;
  integer     num_checks = 0;
  integer     i;
  // 200 MHz reference clock
  always #2.5 clk = ~clk;
  gcfg_top u_dut (
    .REF_CLK_I(clk), .RST_I(rst), .IO_ADDR_I(addr), .IO_WDATA_I(wdat), .IO_WR_I(wr), .IO_RD_I(rd),
    .IO_RDATA_O(rdata), .IO_ACK_O(ack), .STRAP_PORT_SEL_I(s_ps), .STRAP_FLOPPY_DIS_I(s_fd),
    .READY_O(ready), .CONFIG_MODE_O(cmode), .CONFIG_LOCKED_O(locked), .PORT_SELECT_O(psel),
    .FLOPPY_ENABLE_O(fen), .FLOPPY_HIZ_O(hiz[0]), .PRINTER_HIZ_O(hiz[1]), .SERIAL_A_HIZ_O(hiz[2]),
    .SERIAL_B_HIZ_O(hiz[3]),
    .PRINTER_OE_I(prn_oe), .SERIAL_A_OE_I(sa_oe), .SERIAL_B_OE_I(sb_oe), .PRINTER_OE_O(prn_oe_o),
    .SERIAL_A_OE_O(sa_oe_o), .SERIAL_B_OE_O(sb_oe_o), .FLOPPY_IRQ_I(f_irq), .FLOPPY_DOR_IRQ_GATE_I(f_gate),
    .PRINTER_IRQ_I(p_irq), .PRINTER_CTRL_IRQ_GATE_I(p_gate), .SERIAL_IRQ_I(s_irq), .FLOPPY_IRQ_O(f_irq_o),
    .PRINTER_IRQ_O(p_irq_o), .SERIAL_IRQ_O(s_irq_o), .FLOPPY_LEGACY_IRQ_OFF_O(f_leg),
    .PRINTER_LEGACY_IRQ_OFF_O(p_leg),
    .SERIAL_LEGACY_IRQ_OFF_O(s_leg), .PARALLEL_MODE_O(pmode), .PARALLEL_PORT_EN_O(pen),
    .FLOPPY_PIN_OUT_I(f_out), .FLOPPY_PIN_OE_I(f_oe), .ALT_PIN_OUT_I(a_out), .ALT_PIN_OE_I(a_oe),
    .SHARED_PIN_IN_I(pin_in), .SHARED_PIN_OUT_O(sh_out), .SHARED_PIN_OE_O(sh_oe), .FLOPPY_PIN_IN_O(f_in_o),
    .ALT_PIN_IN_O(a_in_o)
  );
  task end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one strobe cycle, then an idle cycle so no strobe is set twice in one step
  task io(input w, input [15:0] a, input [7:0] d, input e_ack, input [7:0] e_rd);
    addr = a;
    wdat = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    chk(ack, e_ack);
    if (!w && e_ack)
      chk(rdata, e_rd);
    wr = 1'b0;
    rd = 1'b0;
    @(negedge clk);
  endtask
  task enter(input [15:0] p);
    io(1'b1, p, 8'h87, 1'b1, 8'h00);
    io(1'b1, p, 8'h87, 1'b1, 8'h00);
  endtask
  task wreg(input [15:0] p, input [7:0] idx, input [7:0] v);
    io(1'b1, p, idx, 1'b1, 8'h00);
    io(1'b1, p + 16'h0001, v, 1'b1, 8'h00);
  endtask
  task rreg(input [15:0] p, input [7:0] idx, input [7:0] e);
    io(1'b1, p, idx, 1'b1, 8'h00);
    io(1'b0, p + 16'h0001, 8'h00, 1'b1, e);
  endtask
  // straps are held steady across release, ready awaited under a bound
  task do_reset(input ps, input fd);
    rst = 1'b1;
    s_ps = ps;
    s_fd = fd;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 8 && ready !== 1'b1; i = i + 1)
      @(negedge clk);
    if (ready !== 1'b1) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  endtask
  task t_reset;
    do_reset(1'b0, 1'b0);
    chk(psel, 1'b0);
    chk(fen, 1'b1);
    enter(LO);
    chk(f_in_o, 13'h0F0F);
    chk(a_in_o, 13'h1FFF);
    rreg(LO, 8'h25, 8'h00);
    rreg(LO, 8'h26, 8'h00);
    rreg(LO, 8'h28, 8'h00);
  endtask
  task t_tristate;
    prn_oe = 8'hFF;
    sa_oe = 4'hF;
    sb_oe = 4'hF;
    f_oe = 13'h1FFF;
    wreg(LO, 8'h25, 8'hFF);
    rreg(LO, 8'h25, 8'h39);
    chk(hiz, 4'hF);
    chk(prn_oe_o, 8'h00);
    chk(sa_oe_o, 4'h0);
    chk(sb_oe_o, 4'h0);
    chk(sh_oe, 13'h0000);
    wreg(LO, 8'h25, 8'h10);
    @(negedge clk);
    chk(hiz, 4'h4);
    chk(sa_oe_o, 4'h0);
    chk(sb_oe_o, 4'hF);
    chk(prn_oe_o, 8'hFF);
    chk(sh_oe, 13'h1FFF);
    wreg(LO, 8'h25, 8'h00);
  endtask
  task t_legacy;
    f_irq = 1'b1;
    p_irq = 1'b1;
    s_irq = 6'h2A;
    repeat (2) @(negedge clk);
    chk(f_irq_o, 1'b0);
    chk(p_irq_o, 1'b0);
    chk(s_irq_o, 6'h2A);
    f_gate = 1'b1;
    p_gate = 1'b1;
    repeat (2) @(negedge clk);
    chk(f_irq_o, 1'b1);
    chk(p_irq_o, 1'b1);
    f_gate = 1'b0;
    p_gate = 1'b0;
    wreg(LO, 8'h26, 8'h0A);
    @(negedge clk);
    chk(f_leg, 1'b1);
    chk(p_leg, 1'b0);
    chk(f_irq_o, 1'b1);
    chk(p_irq_o, 1'b0);
    chk(s_leg, 6'h01);
    chk(s_irq_o, 6'h2A);
    wreg(LO, 8'h28, 8'hFF);
    rreg(LO, 8'h28, 8'hF7);
    chk(s_leg, 6'h3D);
    chk(pen, 1'b0);
    wreg(LO, 8'h28, 8'h53);
    chk(s_leg, 6'h15);
    chk(pen, 1'b1);
    chk(pmode, 3'h3);
    wreg(LO, 8'h26, 8'h00);
  endtask
  task t_lock;
    wreg(LO, 8'h26, 8'h20);
    chk(locked, 1'b1);
    rreg(LO, 8'h25, 8'hFF);
    wreg(LO, 8'h25, 8'h11);
    wreg(LO, 8'h26, 8'h00);
    rreg(LO, 8'h25, 8'h00);
  endtask
  task t_port;
    wreg(LO, 8'h26, 8'h40);
    chk(psel, 1'b1);
    io(1'b1, LO, 8'hAA, 1'b0, 8'h00);
    io(1'b1, HI, 8'hAA, 1'b1, 8'h00);
    chk(cmode, 1'b0);
    io(1'b0, HI + 16'h0001, 8'h00, 1'b1, 8'hFF);
    for (i = 0; i < 2; i = i + 1)
      io(1'b1, LO, 8'h87, 1'b0, 8'h00);
    enter(HI);
    chk(cmode, 1'b1);
    rreg(HI, 8'h26, 8'h40);
  endtask
  task t_strap;
    a_out = 13'h0A5A;
    a_oe = 13'h1234;
    f_out = 13'h15A5;
    do_reset(1'b1, 1'b1);
    chk(psel, 1'b1);
    chk(fen, 1'b0);
    enter(HI);
    rreg(HI, 8'h26, 8'h40);
    chk(sh_out, 13'h0A5A);
    chk(sh_oe, 13'h1234);
    chk(a_in_o, 13'h0F0F);
    chk(f_in_o, 13'h1FFF);
    wreg(HI, 8'h24, 8'h00);
    @(negedge clk);
    chk(fen, 1'b1);
    chk(sh_out, 13'h15A5);
    chk(f_in_o, 13'h0F0F);
    chk(a_in_o, 13'h1FFF);
  endtask
  // main sequence
  initial begin
    t_reset;
    t_tristate;
    t_legacy;
    t_lock;
    t_port;
    t_strap;
    end_sim;
  end
endmodule
